/* src/see_pkg.sv */
/*
 * shared constants and carrier types of the serial eeprom slave.
 * assumes a 20 MHz system clock; all timing counts derive from it.
 */
package see_pkg;
	// system clock period
	localparam int unsigned CLK_PERIOD_NS = 50;
	// widest pulse that must still be rejected on the pins
	localparam int unsigned GLITCH_NS = 50;
	// least time, rounded up to whole cycles
	localparam int unsigned GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// the agreeing second and third flops already span one cycle, so the
	// hold adds only the rest; a longer hold also eats valid 100 ns pulses
	// and pushes the acknowledge release closer to the next scl rise
	localparam logic [3:0] GLITCH_HOLD = 4'(GLITCH_CYCLES - 1);
	// internally timed write cycle, plain default
	localparam int unsigned WRITE_CYCLE_US = 5000;
	localparam int unsigned WRITE_CYCLES_DEF = (WRITE_CYCLE_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 20;
	// memory geometry
	localparam int unsigned MEM_AW = 9;
	localparam int unsigned MEM_WORDS = 512;
	localparam int unsigned PAGE_AW = 3;
	localparam int unsigned PAGE_BYTES = 8;
	// fixed device code in the upper nibble of the slave address
	localparam logic [3:0] DEV_CODE = 4'hA;
	// bit counting within a byte
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] FIRST_TX_BIT = 4'h1;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [PAGE_AW:0] PAGE_END = 4'h8;

	// filtered pin levels
	typedef struct packed {
		logic scl;
		logic sda;
	} see_pins_t;

	// one memory write
	typedef struct packed {
		logic we;
		logic [MEM_AW-1:0] addr;
		logic [7:0] data;
	} see_wr_t;

	// byte protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_END,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} see_state_t;

	// which byte of a frame is being received
	typedef enum logic [1:0] {
		K_DEV,
		K_MHI,
		K_MLO,
		K_DATA
	} see_kind_t;
endpackage

/* src/see_glitch_filter.sv */
/*
 * one pin input: three-flop synchroniser and pulse-width filter.
 * assumes the pin idles high (pulled up) and is asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module see_glitch_filter #(
	parameter logic [3:0] HOLD = see_pkg::GLITCH_HOLD
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic raw,
	output logic clean
);
	import see_pkg::*;

	logic sync1; // first stage, read by sync2 only
	logic sync2;
	logic sync3;
	logic [3:0] cnt; // cycles the new level has held
	wire agree = sync2 == sync3;
	wire differ = agree && (sync3 != clean);

	// synchroniser chain
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// reject short pulses
	// a level must hold past the filter time before it is taken
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt <= CNT_ZERO;
			clean <= 1'b1;
		end else if (!differ) begin
			cnt <= CNT_ZERO;
		end else if (cnt >= HOLD) begin
			cnt <= CNT_ZERO;
			clean <= sync3;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* src/see_mem.sv */
/*
 * 512-byte array with one write port and a registered read port.
 * assumes contents are undefined until written; no reset on the array.
 */
`timescale 1ns/100ps
`default_nettype none
module see_mem (
	input wire logic clk,
	input wire logic reset,
	input wire see_pkg::see_wr_t wr,
	input wire logic [see_pkg::MEM_AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	import see_pkg::*;

	logic [7:0] cells [0:MEM_WORDS-1]; // storage array

	// write port
	always_ff @(posedge clk) begin
		if (wr.we) begin
			cells[wr.addr] <= wr.data;
		end
	end

	// read port, one cycle latency, far below a bit time
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule
`default_nettype wire

/* src/see_top.sv */
/*
 * serial eeprom slave: two-wire protocol engine, page buffer,
 * address counter and internally timed write cycle.
 * assumes scl and sda arrive asynchronously from the pins and that the
 * pad combines sda_out/sda_oe as an open-drain driver with a pull-up.
 */
// Overview of operation
// - write framed by address byte, direction zero
// - two address bytes, upper first, each acknowledged
// - every write data byte acknowledged low
// - stop after data starts timed write
// - one to eight bytes, one write cycle
// - further bytes increment low three bits
// - page end wraps to page start
// - repeated location keeps newest byte
// - stop in page write commits buffer
// - polling: address byte unacknowledged while busy
// - busy only after the closing stop
// - reads framed with direction bit one
// - counter holds last address plus one
// - current read sends counter byte msb first
// - high ack then stop ends read
// - read past top wraps to zero
// - write ending page end wraps in page
// - dummy write loads address for read
// - low ack sends next byte
// - sequential read wraps top to zero
// - pulses under filter time rejected
// - answer only matching device and slave code
// - sample on scl rise, drive on fall
// - no ack nor stop: stay released
`timescale 1ns/100ps
`default_nettype none
module see_top #(
	parameter int unsigned WRITE_CYCLES = see_pkg::WRITE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] slave_address_compare_reg,
	output logic write_busy
);
	import see_pkg::*;

	see_pins_t pins; // filtered pin levels
	see_pins_t pins_q; // previous filtered levels
	see_state_t state; // byte protocol state
	see_state_t next_state;
	see_kind_t kind; // byte being received
	see_kind_t next_kind;
	logic [3:0] bit_cnt; // bits done in this byte
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg; // shift register, both ways
	logic [7:0] next_shreg;
	logic next_oe;
	logic want_ack; // acknowledge decided for this byte
	logic next_want_ack;
	logic rd_mode; // direction bit of the frame
	logic [MEM_AW-1:0] addr; // internal address counter
	logic [7:0] page_buf [0:PAGE_BYTES-1]; // pending page data
	logic [PAGE_BYTES-1:0] valid; // locations holding pending data
	logic [MEM_AW-PAGE_AW-1:0] page; // page under commit
	logic [TIMER_W-1:0] timer; // write cycle countdown
	logic [PAGE_AW:0] commit_idx; // copy position in the page
	logic [7:0] rd_data; // memory byte at the counter
	see_wr_t wr; // memory write port

	// pin filters, one per line
	see_glitch_filter #(
		.HOLD(GLITCH_HOLD)
	) u_scl_filt (
		.clk(clk),
		.reset(reset),
		.raw(scl_in),
		.clean(pins.scl)
	);

	see_glitch_filter #(
		.HOLD(GLITCH_HOLD)
	) u_sda_filt (
		.clk(clk),
		.reset(reset),
		.raw(sda_in),
		.clean(pins.sda)
	);

	// byte storage
	see_mem u_mem (
		.clk(clk),
		.reset(reset),
		.wr(wr),
		.rd_addr(addr),
		.rd_data(rd_data)
	);

	wire scl_rise = pins.scl && !pins_q.scl;
	wire scl_fall = !pins.scl && pins_q.scl;
	// start and stop need scl high across the sda change
	wire bus_start = pins.scl && pins_q.scl && pins_q.sda && !pins.sda;
	wire bus_stop = pins.scl && pins_q.scl && !pins_q.sda && pins.sda;
	wire [7:0] rx_byte = {shreg[6:0], pins.sda};
	// device code and slave code compare
	wire addr_match = (rx_byte[7:4] == DEV_CODE) && (rx_byte[3:1] == slave_address_compare_reg);
	// no acknowledge to the address byte while busy
	wire ack_decide = (kind != K_DEV) || (addr_match && !write_busy);
	wire rx_done = (state == ST_RX) && scl_rise && (bit_cnt == LAST_BIT);
	wire tx_done = (state == ST_TX) && scl_fall && (bit_cnt == BYTE_BITS);
	wire data_in = rx_done && (kind == K_DATA) && !write_busy;
	// commit only on the stop after data
	wire commit = bus_stop && !write_busy && (valid != '0);
	wire write_end = write_busy && (timer == '0);
	wire copying = write_busy && (commit_idx < PAGE_END);
	wire [PAGE_AW-1:0] copy_slot = commit_idx[PAGE_AW-1:0];
	wire [PAGE_AW-1:0] low_next = addr[PAGE_AW-1:0] + 3'h1;
	wire [MEM_AW-1:0] addr_next = addr + 9'h001;

	// pending bytes go to the array during the write cycle
	assign wr.we = copying && valid[copy_slot];
	assign wr.addr = {page, copy_slot};
	assign wr.data = page_buf[copy_slot];

	// pin history for edge detection
	always_ff @(posedge clk) begin
		if (reset) begin
			pins_q <= '1;
		end else begin
			pins_q <= pins;
		end
	end

	// next protocol state
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_oe = sda_oe;
		next_want_ack = want_ack;
		if (bus_start) begin
			// a start restarts framing from any state
			next_state = ST_RX;
			next_kind = K_DEV;
			next_bit_cnt = CNT_ZERO;
			next_oe = 1'b0;
		end else if (bus_stop) begin
			// stop ends any read or write
			next_state = ST_IDLE;
			next_oe = 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					next_oe = 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						next_shreg = rx_byte;
						if (bit_cnt == LAST_BIT) begin
							next_state = ST_RX_END;
							next_want_ack = ack_decide;
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				ST_RX_END: begin
					if (scl_fall) begin
						// acknowledge low on the ninth clock
						if (want_ack) begin
							next_oe = 1'b1;
							next_state = ST_RX_ACK;
						end else begin
							next_state = ST_IDLE;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						if (rd_mode) begin
							// first data bit on the fall after ack
							next_oe = !rd_data[7];
							next_shreg = {rd_data[6:0], 1'b0};
							next_bit_cnt = FIRST_TX_BIT;
							next_state = ST_TX;
						end else begin
							next_oe = 1'b0;
							next_bit_cnt = CNT_ZERO;
							next_state = ST_RX;
							next_kind = (kind == K_DEV) ? K_MHI : (kind == K_MHI) ? K_MLO : K_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == BYTE_BITS) begin
							// release for the master's acknowledge
							next_oe = 1'b0;
							next_state = ST_TX_ACK;
						end else begin
							next_oe = !shreg[7];
							next_shreg = {shreg[6:0], 1'b0};
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						// low ack loads the next byte
						// otherwise stay released until start or stop
						next_state = pins.sda ? ST_IDLE : ST_RX_ACK;
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_oe = 1'b0;
				end
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			kind <= K_DEV;
			bit_cnt <= CNT_ZERO;
			shreg <= 8'h00;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			want_ack <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			sda_oe <= next_oe;
			sda_out <= 1'b0;
			want_ack <= next_want_ack;
		end
	end

	// direction bit taken from the address byte
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_mode <= 1'b0;
		end else if (rx_done && (kind == K_DEV)) begin
			rd_mode <= rx_byte[0];
		end
	end

	// address counter
	always_ff @(posedge clk) begin
		if (reset) begin
			addr <= '0;
		end else if (rx_done && !write_busy && (kind == K_MHI)) begin
			// dummy write loads the upper address bit
			addr[MEM_AW-1] <= rx_byte[0];
		end else if (rx_done && !write_busy && (kind == K_MLO)) begin
			addr[7:0] <= rx_byte;
		end else if (data_in) begin
			// only the low three bits step, wrapping in page
			addr[PAGE_AW-1:0] <= low_next;
		end else if (tx_done) begin
			// read step wraps the top address to zero
			addr <= addr_next;
		end
	end

	// page buffer; the mark is a set that wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			valid <= '0;
		end else if (data_in) begin
			// a later byte overwrites the same slot
			page_buf[addr[PAGE_AW-1:0]] <= rx_byte;
			valid[addr[PAGE_AW-1:0]] <= 1'b1;
		end else if (write_end) begin
			valid <= '0;
		end
	end

	// internally timed write cycle
	// inputs are ignored by gating data and acks with write_busy
	always_ff @(posedge clk) begin
		if (reset) begin
			write_busy <= 1'b0;
			timer <= '0;
			commit_idx <= '0;
			page <= '0;
		end else if (commit) begin
			write_busy <= 1'b1;
			timer <= TIMER_W'(WRITE_CYCLES - 1);
			commit_idx <= '0;
			page <= addr[MEM_AW-1:PAGE_AW];
		end else if (write_end) begin
			write_busy <= 1'b0;
		end else if (write_busy) begin
			timer <= timer - 1'b1;
			if (copying) begin
				commit_idx <= commit_idx + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/see_m.sv */
/*
 * two-wire bus master model: start, stop, byte out, byte in.
 * assumes a pull-up on sda, so a released wire reads high.
 */
`timescale 1ns/100ps
`default_nettype none
module see_m (
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// data moves in low phase
	// low phase is the long one: the slave answers about 225 ns after a
	// fall, and its release must be on the wire before the next rise
	task automatic bit_io(input logic b, input logic g, output logic r);
		scl = 1'b0;
		#50 sda_drv = b;
		#250 scl = 1'b1;
		// optional one-clock spike, too short to count
		if (g) sda_drv = 1'b0;
		#50 sda_drv = b;
		#40 r = sda;
		#10;
	endtask
	// start, or repeated start after a bit
	task automatic start();
		scl = 1'b0;
		#50 sda_drv = 1'b1;
		// rise only after the slave has let go of its acknowledge
		#250 scl = 1'b1;
		#200 sda_drv = 1'b0;
		#200;
	endtask
	task automatic stop();
		scl = 1'b0;
		#50 sda_drv = 1'b0;
		#250 scl = 1'b1;
		#200 sda_drv = 1'b1;
		#200;
	endtask
	task automatic put(input logic [7:0] d, input logic g, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], g && i == 7, r);
		bit_io(1'b1, 1'b0, ack);
	endtask
	task automatic get(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, 1'b0, r);
			d[i] = r;
		end
		bit_io(nak, 1'b0, r);
	endtask
endmodule
`default_nettype wire

/* tb/see_properties.sv */
/*
 * checker on the slave pins, bound into see_top.
 * assumes scl_in and sda_in carry the resolved wire levels.
 */
`timescale 1ns/100ps
`default_nettype none
module see_properties #(
	parameter int unsigned WRITE_CYCLES = 200
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [2:0] slave_address_compare_reg,
	input wire logic write_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic scl_q; // pins one clock back
	logic sda_q;
	logic [3:0] fall_age; // clocks since scl fell
	logic [3:0] stop_age; // clocks since a stop
	logic [19:0] busy_len; // clocks of write cycle
	wire logic scl_fall = scl_q && !scl_in;
	wire logic stop_seen = scl_in && sda_in && !sda_q;
	// ages saturate so a quiet bus never wraps
	always_ff @(posedge clk) begin
		scl_q <= scl_in;
		sda_q <= sda_in;
		fall_age <= reset ? 4'hF : scl_fall ? 4'h0 : fall_age + 4'(fall_age != 4'hF);
		stop_age <= reset ? 4'hF : stop_seen ? 4'h0 : stop_age + 4'(stop_age != 4'hF);
		busy_len <= write_busy ? busy_len + 20'h00001 : 20'h00000;
	end
	drive_zero_a: assert property (sda_out == 1'b0)
		else $error("sda value not zero");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=> !sda_oe && !write_busy)
		else $error("outputs active after reset");
	fall_drive_a: assert property ($changed(sda_oe) |-> fall_age inside {[4'h2:4'h6]})
		else $error("sda drive moved away from scl fall");
	ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*7])
		else $error("low drive shorter than a bit");
	release_hold_a: assert property ($fell(sda_oe) |-> !sda_oe [*7])
		else $error("release shorter than a bit");
	busy_start_a: assert property ($rose(write_busy) |-> stop_age < 4'hA)
		else $error("write cycle without a stop");
	busy_quiet_a: assert property (write_busy |-> !sda_oe)
		else $error("sda driven during write cycle");
	busy_len_a: assert property ($fell(write_busy) |->
		busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	cover property ($rose(write_busy));
	cover property ($fell(write_busy));
	cover property ($rose(sda_oe));
endmodule
bind see_top see_properties #(.WRITE_CYCLES(WRITE_CYCLES)) see_properties_i (.clk(clk),
	.reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.slave_address_compare_reg(slave_address_compare_reg), .write_busy(write_busy));
`default_nettype wire

/* tb/see_top_bench.sv */
/*
 * bench for the eeprom slave: master model on the wire, memory model here.
 * assumes the checker binds itself from its own file.
 */
`timescale 1ns/100ps
`default_nettype none
module see_top_bench;
	import see_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] sac; // slave code of this run
	logic sda_out;
	logic sda_oe;
	logic write_busy;
	logic scl;
	logic sda_drv;
	wire logic sda = sda_drv & ~sda_oe; // open drain, pull-up
	logic [7:0] mem_m [MEM_WORDS]; // expected contents
	logic [8:0] cnt_m; // expected address counter
	logic [16:0] lfsr = 17'h1156C;
	int mismatches = 0;
	int n_tests = 0;
	logic ack;
	logic [7:0] d;
	logic [8:0] a;
	always #25 clk = ~clk;
	see_top #(.WRITE_CYCLES(200)) see_top_i (.clk(clk), .reset(reset), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.slave_address_compare_reg(sac), .write_busy(write_busy));
	see_m see_m_i (.sda(sda), .scl(scl), .sda_drv(sda_drv));
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
		return lfsr[7:0];
	endfunction
	// address byte of this slave
	function automatic logic [7:0] dev(input logic rw);
		return {DEV_CODE, sac, rw};
	endfunction
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t bit %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t byte %h not %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// frame header: address byte, then both memory address bytes
	task automatic hdr(input logic [8:0] ad);
		see_m_i.start();
		see_m_i.put(dev(1'b0), 1'b0, ack);
		chk_bit(ack, 1'b0);
		see_m_i.put({7'h00, ad[8]}, 1'b0, ack);
		chk_bit(ack, 1'b0);
		see_m_i.put(ad[7:0], 1'b0, ack);
		chk_bit(ack, 1'b0);
	endtask
	// write n random bytes, then poll until the cycle ends
	task automatic wr(input logic [8:0] ad, input int n);
		logic [2:0] o;
		logic [7:0] v;
		o = ad[2:0];
		hdr(ad);
		for (int i = 0; i < n; i++) begin
			v = rnd();
			see_m_i.put(v, 1'b0, ack);
			chk_bit(ack, 1'b0);
			mem_m[{ad[8:3], o}] = v;
			o++;
		end
		chk_bit(write_busy, 1'b0);
		see_m_i.stop();
		cnt_m = {ad[8:3], o};
		repeat (4) @(negedge clk);
		chk_bit(write_busy, 1'b1);
		for (int i = 0; i < 8; i++) begin
			see_m_i.start();
			see_m_i.put(dev(1'b0), 1'b0, ack);
			see_m_i.stop();
			if (i == 0)
				chk_bit(ack, 1'b1);
			if (ack === 1'b0)
				break;
		end
		chk_bit(ack, 1'b0);
	endtask
	// read n bytes, from ad when r_a, else from the counter
	task automatic rd(input logic [8:0] ad, input logic r_a, input int n);
		if (r_a) begin
			hdr(ad);
			cnt_m = ad;
		end
		see_m_i.start();
		see_m_i.put(dev(1'b1), 1'b0, ack);
		chk_bit(ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			see_m_i.get(i == n - 1, d);
			chk_byte(d, mem_m[cnt_m]);
			cnt_m++;
		end
		see_m_i.stop();
	endtask
	// hang guard: whole run is well under a millisecond
	initial begin
		#3000000;
		mismatches++;
		final_report();
	end
	initial begin
		sac = 3'(rnd());
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		chk_bit(sda_oe, 1'b0);
		see_m_i.start();
		see_m_i.put({4'h5, sac, 1'b0}, 1'b0, ack);
		chk_bit(ack, 1'b1);
		see_m_i.start();
		see_m_i.put({DEV_CODE, ~sac, 1'b0}, 1'b0, ack);
		chk_bit(ack, 1'b1);
		see_m_i.stop();
		wr(9'h000, 8);
		wr(9'h1FE, 10);
		rd(9'h000, 1'b0, 1);
		rd(9'h1FE, 1'b1, 4);
		rd(9'h1FF, 1'b1, 1);
		rd(9'h000, 1'b0, 1);
		// high ack and no stop: the line stays free
		see_m_i.start();
		see_m_i.put(dev(1'b1), 1'b0, ack);
		see_m_i.get(1'b1, d);
		chk_byte(d, mem_m[cnt_m]);
		cnt_m++;
		see_m_i.get(1'b1, d);
		chk_byte(d, 8'hFF);
		see_m_i.stop();
		// spike inside an address byte
		see_m_i.start();
		see_m_i.put(dev(1'b0), 1'b1, ack);
		chk_bit(ack, 1'b0);
		see_m_i.stop();
		repeat (6) @(negedge clk);
		chk_bit(write_busy, 1'b0);
		for (int k = 0; k < 4; k++) begin
			a = 9'({rnd(), rnd()});
			wr(a, 1);
			rd(a, 1'b1, 1);
		end
		final_report();
	end
endmodule
`default_nettype wire
